// >>> rtl/mic_intc.sv
// Interrupt controller: pin detection, masking, priority, entry and return
//
// Function
// RQ1: Global enable bit allows maskable interrupts; clear blocks all except non-maskable.
// RQ2: Port C input edge polarity by select bit; port A/B low level or falling.
// RQ3: Non-maskable falling edge sets a latch, cleared when its routine starts.
// RQ4: Each port input in edge mode has a latch, set by edge, cleared at entry.
// RQ5: One edge during service is kept and served later; further edges are lost.
// RQ6: Level mode stores nothing; pin must be low at the sampling moment.
// RQ7: Lines sampled at each instruction end; pending request branches to its routine.
// RQ8: With global enable low, non-maskable works but cannot wake from low power.
// RQ9: Three carry/zero flag sets; entry switches to the set of the new level.
// RQ10: Entry pushes the current program counter onto the first stack level.
// RQ11: During service maskable lines are inhibited; non-maskable may still interrupt.
// RQ12: Last entry step after latch clear loads the vector address into the PC.
// RQ13: Return instruction restores the previous flag set and pops the saved PC.
// RQ14: Service software saves its registers and polls flags behind shared vectors.
// RQ15: Timer-1 zero flag reaches the core only with its enable bit set.
// RQ16: Converter done flag forwarded only with its enable bit set.
// RQ17: Reload timer overflow, compare and input flags each gated by their enable.
// RQ18: Serial done flag raises a request only with its enable bit set.
// RQ19: Port pin requests are masked only by the global enable bit.
// RQ20: Fixed priority vector 1 highest to 4 lowest; maskable never nest.
// RQ21: Each peripheral flag passes to the core only with its mask bit one.
// RQ22: Masked flags are left untouched, so requests appear once unmasked.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps

module mic_intc
  import mic_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           rst_b,
  input  wire logic [`MIC_ADDR_W-1:0]         avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [`MIC_DATA_W-1:0]         avs_writedata,
  output      logic [`MIC_DATA_W-1:0]         avs_readdata,
  output      logic                           avs_waitrequest,
  input  wire mic_pkg::mic_pins_t             pins,
  input  wire mic_pkg::mic_flags_t            flags,
  input  wire mic_pkg::mic_core_req_t         coreReq,
  output      mic_pkg::mic_core_rsp_t         coreRsp,
  output      logic                           wakeReq
);
  import mic_pkg::*;

  mic_state_t s_q;
  mic_state_t s_d;

  logic nmiFall;
  logic abFall;
  logic cEdge;
  logic req1;
  logic req2;
  logic req3;
  logic req4;
  logic maskReq;
  logic busReq;

  // Two-bit index of a flag set for a level
  function automatic logic [1:0] lvlIdx(input mic_level_t lv);
    lvlIdx = 2'(lv);
  endfunction

  // Byte-wide register index match used by the write decode
  function automatic logic hit(input logic [`MIC_ADDR_W-1:0] a,
                               input logic [`MIC_ADDR_W-1:0] idx);
    hit = (a == idx);
  endfunction

  assign busReq          = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~s_q.ack;
  assign avs_readdata    = s_q.readData;
  assign coreRsp         = s_q.rsp;

  // Pin edge detectors
  always_comb begin
    nmiFall = s_q.nmiPrev & ~pins.nmiPin; // RQ3
    abFall  = s_q.abPrev & ~pins.portAbPin;
    cEdge   = s_q.portCEdgeSelect ? (~s_q.cPrev & pins.portCPin)
                                  : (s_q.cPrev & ~pins.portCPin); // RQ2
  end

  // Gated requests per vector
  always_comb begin
    req1 = s_q.portAbLevelSelect ? ~pins.portAbPin : s_q.latchAb; // RQ2 RQ6
    req2 = s_q.latchC
         | (flags.serialDoneFlag & s_q.serialDoneIrqEnable); // RQ18 RQ21
    req3 = (flags.reloadOverflowFlag & s_q.reloadOverflowIrqEnable)
         | (flags.compareMatchFlag & s_q.reloadCompareIrqEnable)
         | (flags.captureInputFlag & s_q.reloadInputIrqEnable); // RQ17 RQ21
    req4 = (flags.timer1ZeroFlag & s_q.timer1IrqEnable) // RQ15
         | (flags.converterDoneFlag & s_q.converterIrqEnable); // RQ16 RQ22
    maskReq = s_q.globalIrqEnable & (req1 | req2 | req3 | req4); // RQ1 RQ19
  end

  // Low-power exit request
  assign wakeReq = maskReq | (s_q.latchNmi & s_q.globalIrqEnable); // RQ8

  always_comb begin
    s_d = s_q;
    s_d.rsp.irqTake       = 1'b0;
    s_d.rsp.pcRestoreLoad = 1'b0;
    s_d.rsp.czLoad        = 1'b0;

    // Bus slave: answer one cycle after the request appears
    s_d.ack = busReq & ~s_q.ack;
    if (busReq & ~s_q.ack) begin
      s_d.readData = '0;
      if (avs_read) begin
        unique case (avs_address)
          `MIC_IDX_CONV: begin
            s_d.readData[`MIC_CONV_IRQ_EN] = s_q.converterIrqEnable;
            s_d.readData[`MIC_CONV_DONE]   = flags.converterDoneFlag;
          end
          `MIC_IDX_TSCR: begin
            s_d.readData[`MIC_TSCR_IRQ_EN] = s_q.timer1IrqEnable;
            s_d.readData[`MIC_TSCR_ZERO]   = flags.timer1ZeroFlag;
          end
          `MIC_IDX_RELOAD: begin
            s_d.readData[`MIC_RLD_OVERFLOW_EN] = s_q.reloadOverflowIrqEnable;
            s_d.readData[`MIC_RLD_COMPARE_EN]  = s_q.reloadCompareIrqEnable;
            s_d.readData[`MIC_RLD_INPUT_EN]    = s_q.reloadInputIrqEnable;
          end
          `MIC_IDX_SERIAL: begin
            s_d.readData[`MIC_SER_DONE_EN] = s_q.serialDoneIrqEnable;
          end
          `MIC_IDX_STATUS: begin
            s_d.readData[`MIC_ST_LATCH_C]   = s_q.latchC;
            s_d.readData[`MIC_ST_LATCH_AB]  = s_q.latchAb;
            s_d.readData[`MIC_ST_LATCH_NMI] = s_q.latchNmi;
            s_d.readData[`MIC_ST_DEPTH +: 2] = s_q.depth;
            s_d.readData[`MIC_ST_LEVEL +: 2] = lvlIdx(s_q.level);
          end
          default: s_d.readData = '0;
        endcase
      end
    end
    if (avs_write & s_q.ack) begin
      if (hit(avs_address, `MIC_IDX_OPTION)) begin
        s_d.globalIrqEnable   = avs_writedata[`MIC_OPT_GLOBAL_EN]; // RQ1
        s_d.portAbLevelSelect = avs_writedata[`MIC_OPT_AB_LEVEL];
        s_d.portCEdgeSelect   = avs_writedata[`MIC_OPT_C_EDGE];
      end
      if (hit(avs_address, `MIC_IDX_CONV)) begin
        s_d.converterIrqEnable = avs_writedata[`MIC_CONV_IRQ_EN];
      end
      if (hit(avs_address, `MIC_IDX_TSCR)) begin
        s_d.timer1IrqEnable = avs_writedata[`MIC_TSCR_IRQ_EN];
      end
      if (hit(avs_address, `MIC_IDX_RELOAD)) begin
        s_d.reloadOverflowIrqEnable = avs_writedata[`MIC_RLD_OVERFLOW_EN];
        s_d.reloadCompareIrqEnable  = avs_writedata[`MIC_RLD_COMPARE_EN];
        s_d.reloadInputIrqEnable    = avs_writedata[`MIC_RLD_INPUT_EN];
      end
      if (hit(avs_address, `MIC_IDX_SERIAL)) begin
        s_d.serialDoneIrqEnable = avs_writedata[`MIC_SER_DONE_EN];
      end
    end

    // Pin history
    s_d.nmiPrev = pins.nmiPin;
    s_d.abPrev  = pins.portAbPin;
    s_d.cPrev   = pins.portCPin;

    // Return: restore flags and saved PC
    if (coreReq.irqReturn) begin
      s_d.czSet[lvlIdx(s_q.level)] = coreReq.cz;
      s_d.level = (s_q.level == MIC_NMI) ? s_q.prevLevel : MIC_NORMAL; // RQ13
      s_d.prevLevel = MIC_NORMAL;
      s_d.rsp.czLoad    = 1'b1;
      s_d.rsp.czLoadVal = s_q.czSet[lvlIdx(s_d.level)]; // RQ13
      if (s_q.depth != `MIC_RST_DEPTH) begin
        s_d.depth = s_q.depth - 2'h1;
        s_d.rsp.pcRestoreLoad = 1'b1;
        s_d.rsp.pcRestore     = s_q.stack[s_d.depth[0]]; // RQ13
      end
    end else if (coreReq.instrEnd) begin // RQ7
      if (s_q.latchNmi && s_q.level != MIC_NMI
          && s_q.depth != `MIC_DEPTH_MAX) begin // RQ11
        s_d.czSet[lvlIdx(s_q.level)] = coreReq.cz; // RQ9
        s_d.rsp.czLoadVal = s_q.czSet[lvlIdx(MIC_NMI)];
        s_d.rsp.czLoad    = 1'b1;
        s_d.stack[s_q.depth[0]] = coreReq.pc; // RQ10
        s_d.depth     = s_q.depth + 2'h1;
        s_d.prevLevel = s_q.level;
        s_d.level     = MIC_NMI;
        s_d.latchNmi  = 1'b0; // RQ3
        s_d.rsp.vector  = `MIC_VEC_NMI; // RQ12
        s_d.rsp.irqTake = 1'b1;
      end else if (maskReq && s_q.level == MIC_NORMAL) begin // RQ11 RQ20
        s_d.czSet[lvlIdx(s_q.level)] = coreReq.cz; // RQ9
        s_d.rsp.czLoadVal = s_q.czSet[lvlIdx(MIC_IRQ)];
        s_d.rsp.czLoad    = 1'b1;
        s_d.stack[s_q.depth[0]] = coreReq.pc; // RQ10
        s_d.depth     = s_q.depth + 2'h1;
        s_d.prevLevel = MIC_NORMAL;
        s_d.level     = MIC_IRQ;
        s_d.rsp.irqTake = 1'b1;
        if (req1) begin // RQ20
          s_d.latchAb    = 1'b0; // RQ4
          s_d.rsp.vector = `MIC_VEC_1; // RQ12
        end else if (req2) begin
          s_d.latchC     = 1'b0; // RQ4
          s_d.rsp.vector = `MIC_VEC_2;
        end else if (req3) begin
          s_d.rsp.vector = `MIC_VEC_3;
        end else begin
          s_d.rsp.vector = `MIC_VEC_4;
        end
      end
    end

    // Latch sets win over the entry clear; a single bit keeps one extra edge
    if (nmiFall) begin
      s_d.latchNmi = 1'b1; // RQ3
    end
    if (abFall & ~s_q.portAbLevelSelect) begin
      s_d.latchAb = 1'b1; // RQ4 RQ5
    end
    if (s_q.portAbLevelSelect) begin
      s_d.latchAb = 1'b0; // RQ6
    end
    if (cEdge) begin
      s_d.latchC = 1'b1; // RQ4 RQ5
    end
  end

  // Reset enters non-maskable mode so the start routine ends with a return
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q                         <= '0;
      s_q.nmiPrev                 <= `MIC_RST_PIN;
      s_q.abPrev                  <= `MIC_RST_PIN;
      s_q.cPrev                   <= `MIC_RST_PIN;
      s_q.globalIrqEnable         <= `MIC_RST_BIT;
      s_q.level                   <= MIC_NMI;
      s_q.prevLevel               <= MIC_NORMAL;
      s_q.depth                   <= `MIC_RST_DEPTH;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // mic_intc

// >>> rtl/mic_pkg.sv
// Types shared by the interrupt block and its users
package mic_pkg;
  `include "mic_regs.svh"

  typedef enum logic [1:0] {MIC_NORMAL, MIC_IRQ, MIC_NMI} mic_level_t;

  typedef struct packed {
    logic                  instrEnd;
    logic                  irqReturn;
    logic [`MIC_PC_W-1:0]  pc;
    logic [1:0]            cz;
  } mic_core_req_t;

  typedef struct packed {
    logic                  irqTake;
    logic [`MIC_PC_W-1:0]  vector;
    logic                  pcRestoreLoad;
    logic [`MIC_PC_W-1:0]  pcRestore;
    logic                  czLoad;
    logic [1:0]            czLoadVal;
  } mic_core_rsp_t;

  typedef struct packed {
    logic nmiPin;
    logic portAbPin;
    logic portCPin;
  } mic_pins_t;

  typedef struct packed {
    logic timer1ZeroFlag;
    logic converterDoneFlag;
    logic reloadOverflowFlag;
    logic compareMatchFlag;
    logic captureInputFlag;
    logic serialDoneFlag;
  } mic_flags_t;

  typedef struct packed {
    logic                     ack;
    logic [`MIC_DATA_W-1:0]   readData;
    logic                     globalIrqEnable;
    logic                     portAbLevelSelect;
    logic                     portCEdgeSelect;
    logic                     converterIrqEnable;
    logic                     timer1IrqEnable;
    logic                     reloadOverflowIrqEnable;
    logic                     reloadCompareIrqEnable;
    logic                     reloadInputIrqEnable;
    logic                     serialDoneIrqEnable;
    logic                     nmiPrev;
    logic                     abPrev;
    logic                     cPrev;
    logic                     latchNmi;
    logic                     latchAb;
    logic                     latchC;
    mic_level_t               level;
    mic_level_t               prevLevel;
    logic [1:0]               depth;
    logic [1:0][`MIC_PC_W-1:0] stack;
    logic [2:0][1:0]          czSet;
    mic_core_rsp_t            rsp;
  } mic_state_t;
endpackage

// >>> rtl/mic_regs.svh
// Register indices, field positions, reset values and vectors of the interrupt block
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

`define MIC_ADDR_W        8
`define MIC_DATA_W        32
`define MIC_REG_W         8
`define MIC_PC_W          12

`define MIC_IDX_OPTION    8'hC8
`define MIC_IDX_CONV      8'hD1
`define MIC_IDX_TSCR      8'hD4
`define MIC_IDX_RELOAD    8'hD5
`define MIC_IDX_SERIAL    8'hE2
`define MIC_IDX_STATUS    8'hF0

`define MIC_OPT_GLOBAL_EN     4
`define MIC_OPT_AB_LEVEL      5
`define MIC_OPT_C_EDGE        6
`define MIC_CONV_IRQ_EN       5
`define MIC_CONV_DONE         6
`define MIC_TSCR_IRQ_EN       5
`define MIC_TSCR_ZERO         7
`define MIC_RLD_INPUT_EN      5
`define MIC_RLD_COMPARE_EN    6
`define MIC_RLD_OVERFLOW_EN   7
`define MIC_SER_DONE_EN       6

`define MIC_ST_LATCH_C    0
`define MIC_ST_LATCH_AB   1
`define MIC_ST_LATCH_NMI  2
`define MIC_ST_DEPTH      3
`define MIC_ST_LEVEL      5

`define MIC_RST_BIT       1'b0
`define MIC_RST_PIN       1'b1
`define MIC_RST_DEPTH     2'h0
`define MIC_DEPTH_MAX     2'h2

`define MIC_VEC_NMI       12'hFFC
`define MIC_VEC_1         12'hFF6
`define MIC_VEC_2         12'hFF4
`define MIC_VEC_3         12'hFF2
`define MIC_VEC_4         12'hFF0

`endif

// >>> verif/mic_core_model.sv
// Core model: boundaries, returns, vector and restore loads
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   rst_b,
  input wire logic                   doEnd,
  input wire logic                   doReturn,
  input wire mic_pkg::mic_core_rsp_t coreRsp,
  output     mic_pkg::mic_core_req_t coreReq
);
  logic [11:0] pc_q;
  logic [1:0]  cz_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_q <= 12'h100;
      cz_q <= 2'h0;
    end else begin
      if (coreRsp.irqTake) pc_q <= coreRsp.vector;
      else if (coreRsp.pcRestoreLoad) pc_q <= coreRsp.pcRestore;
      else if (doEnd) pc_q <= pc_q + 12'h1;
      // Each instruction disturbs the flags
      if (coreRsp.czLoad) cz_q <= coreRsp.czLoadVal;
      else if (doEnd) cz_q <= cz_q + 2'h1;
    end
  end
  assign coreReq = '{instrEnd: doEnd, irqReturn: doReturn, pc: pc_q, cz: cz_q};
endmodule // mic_core_model

// >>> verif/mic_intc_properties.sv
// Port checker for the interrupt block
`timescale 1ns/1ps
`include "mic_regs.svh"
module mic_intc_properties
  import mic_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   rst_b,
  input wire logic [7:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire mic_pkg::mic_pins_t     pins,
  input wire mic_pkg::mic_flags_t    flags,
  input wire mic_pkg::mic_core_req_t coreReq,
  input wire mic_pkg::mic_core_rsp_t coreRsp,
  input wire logic                   wakeReq
);
  logic globalEnQ;
  logic irqQ;
  logic nmiQ;
  logic take;
  logic mTake;
  assign take = coreRsp.irqTake;
  assign mTake = take && coreRsp.vector != `MIC_VEC_NMI;
  // Shadow of enable and service level, seen from the ports
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      globalEnQ <= 1'b0;
      irqQ <= 1'b0;
      nmiQ <= 1'b1;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == `MIC_IDX_OPTION)
        globalEnQ <= avs_writedata[`MIC_OPT_GLOBAL_EN];
      if (mTake) irqQ <= 1'b1;
      else if (take) nmiQ <= 1'b1;
      else if (coreRsp.czLoad && nmiQ) nmiQ <= 1'b0;
      else if (coreRsp.czLoad) irqQ <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_take_on_end: assert property (take |-> $past(coreReq.instrEnd))
    else $error("take without boundary");
  a_vector_table: assert property (take |-> coreRsp.vector inside
    {12'hFFC, 12'hFF6, 12'hFF4, 12'hFF2, 12'hFF0}) else $error("bad vector");
  a_entry_swap: assert property (take |-> coreRsp.czLoad)
    else $error("no flag swap at entry");
  a_return_answer: assert property (coreReq.irqReturn |=> coreRsp.czLoad && !take)
    else $error("return not answered");
  a_restore_cause: assert property (coreRsp.pcRestoreLoad |-> $past(coreReq.irqReturn))
    else $error("restore without return");
  a_enable_blocks: assert property (mTake |-> $past(globalEnQ))
    else $error("maskable take with enable off");
  a_wake_gated: assert property (!globalEnQ |-> !wakeReq)
    else $error("wake with enable off");
  a_no_nesting: assert property (mTake |-> !irqQ && !nmiQ)
    else $error("maskable nested");
  a_nmi_once: assert property (take && !mTake |-> !nmiQ)
    else $error("nmi inside nmi");
  c_mask: cover property (mTake);
  c_nmi: cover property (take && !mTake);
  c_pop: cover property (coreRsp.pcRestoreLoad);
endmodule // mic_intc_properties

bind mic_intc mic_intc_properties u_props (.mclk(mclk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pins(pins), .flags(flags),
  .coreReq(coreReq), .coreRsp(coreRsp), .wakeReq(wakeReq));

// >>> verif/test_mcu_interrupt_controller.sv
// Self-checking bench for the interrupt block
`timescale 1ns/1ps
`include "mic_regs.svh"
module test_mcu_interrupt_controller;
  import mic_pkg::*;
  logic          mclk, rst_b, rd, wr, doEnd, doReturn, waitreq, wake;
  logic [7:0]    addr;
  logic [31:0]   wdata, rdata, r;
  mic_pins_t     pins;
  mic_flags_t    flags;
  mic_core_req_t req;
  mic_core_rsp_t rsp;
  int            num_errors, checks, i;
  logic [11:0]   pcA, pcB;
  logic [1:0]    czA, czB;
  logic [7:0]    ra [6] = '{8'hD4, 8'hD1, 8'hD5, 8'hD5, 8'hD5, 8'hE2};
  logic [7:0]    en [6] = '{8'h20, 8'h20, 8'h80, 8'h40, 8'h20, 8'h40};
  logic [11:0]   vc [6] = '{12'hFF0, 12'hFF0, 12'hFF2, 12'hFF2, 12'hFF2, 12'hFF4};
  mic_intc dut (.mclk(mclk), .rst_b(rst_b), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .pins(pins), .flags(flags), .coreReq(req),
    .coreRsp(rsp), .wakeReq(wake));
  mic_core_model core (.mclk(mclk), .rst_b(rst_b), .doEnd(doEnd), .doReturn(doReturn),
    .coreRsp(rsp), .coreReq(req));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    // Request held until the edge that sees waitrequest low
    do begin
      @(posedge mclk);
    end while (waitreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic mark;
    // One edge so a pending restore load has landed in the core
    @(posedge mclk);
    pcA = req.pc;
    czA = req.cz;
  endtask
  task automatic step(input logic t, input logic [11:0] v);
    @(posedge mclk);
    doEnd <= 1'b1;
    @(posedge mclk);
    doEnd <= 1'b0;
    @(posedge mclk);
    check(rsp.irqTake, t);
    if (t) check(rsp.vector, v);
  endtask
  task automatic finish_isr(input logic p, input logic [11:0] pc, input logic [1:0] cz);
    @(posedge mclk);
    doReturn <= 1'b1;
    @(posedge mclk);
    doReturn <= 1'b0;
    @(posedge mclk);
    check(rsp.czLoad, 1'b1);
    check(rsp.pcRestoreLoad, p);
    if (p) check(rsp.pcRestore, pc);
    if (p) check(rsp.czLoadVal, cz);
  endtask
  task automatic pulse(input int k);
    repeat (2) begin
      @(posedge mclk);
      pins[k] <= ~pins[k];
    end
    repeat (2) @(posedge mclk);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rst_b = 1'b0;
    {rd, wr, doEnd, doReturn, addr, wdata} = '0;
    pins = 3'h7;
    flags = 6'h0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    bus(1'b0, 8'hF0, 8'h0);
    check(r, 32'h40);
    bus(1'b0, 8'hC8, 8'h0);
    check(r, 32'h0);
    bus(1'b0, 8'h10, 8'h0);
    check(r, 32'h0);
    finish_isr(1'b0, 12'h0, 2'h0);
    $display("Test reset done");
    step(1'b0, 12'h0);
    pulse(1);
    step(1'b0, 12'h0);
    bus(1'b1, 8'hC8, 8'h10);
    bus(1'b0, 8'hF0, 8'h0);
    check(r, 32'h02);
    mark();
    step(1'b1, 12'hFF6);
    pulse(1);
    pulse(1);
    bus(1'b0, 8'hF0, 8'h0);
    check(r, 32'h2A);
    step(1'b0, 12'h0);
    pulse(2);
    pcB = req.pc;
    czB = req.cz;
    step(1'b1, 12'hFFC);
    bus(1'b0, 8'hF0, 8'h0);
    check(r, 32'h52);
    finish_isr(1'b1, pcB, czB);
    finish_isr(1'b1, pcA, czA);
    mark();
    step(1'b1, 12'hFF6);
    finish_isr(1'b1, pcA, czA);
    step(1'b0, 12'h0);
    $display("Test nesting done");
    for (i = 0; i < 6; i++) begin
      flags <= 6'h20 >> i;
      step(1'b0, 12'h0);
      bus(1'b1, ra[i], en[i]);
      mark();
      step(1'b1, vc[i]);
      flags <= 6'h0;
      bus(1'b1, ra[i], 8'h0);
      finish_isr(1'b1, pcA, czA);
    end
    bus(1'b1, 8'hD4, 8'h20);
    bus(1'b1, 8'hE2, 8'h40);
    flags <= 6'h21;
    mark();
    step(1'b1, 12'hFF4);
    flags <= 6'h0;
    finish_isr(1'b1, pcA, czA);
    $display("Test masks done");
    bus(1'b1, 8'hC8, 8'h70);
    pulse(0);
    mark();
    step(1'b1, 12'hFF4);
    finish_isr(1'b1, pcA, czA);
    pins[1] <= 1'b0;
    mark();
    step(1'b1, 12'hFF6);
    pins[1] <= 1'b1;
    finish_isr(1'b1, pcA, czA);
    pulse(1);
    step(1'b0, 12'h0);
    bus(1'b1, 8'hC8, 8'h00);
    pulse(0);
    pulse(2);
    check(wake, 1'b0);
    bus(1'b1, 8'hC8, 8'h10);
    @(posedge mclk);
    check(wake, 1'b1);
    mark();
    step(1'b1, 12'hFFC);
    finish_isr(1'b1, pcA, czA);
    step(1'b1, 12'hFF4);
    $display("Test modes done");
    tally_and_finish();
  end
endmodule // test_mcu_interrupt_controller
